// ===== logic/wsc_top.v
`timescale 1ns/1ns
// Behaviour
// - watchdog counts ticks of its own rc oscillator, also while core sleeps
// - watchdog time-out while running gives a full device reset
// - watchdog time-out while asleep wakes the device without reset
// - any watchdog time-out clears the timeout flag
// - cleared watchdog enable fuse disables the watchdog entirely
// - one prescaler shared by timer and watchdog, assign bit and ratio field
// - clear-watchdog and sleep clear counter and assigned postscaler
// - clear-watchdog clears prescaler count only when assigned to watchdog, assignment unchanged
// - sleep clears watchdog, clears powerdown flag, sets timeout flag, oscillator off
// - port pins hold their drive state during sleep
// - wake on master clear, watchdog, int pin, port change, peripheral
// - master clear in sleep resets; other wake events resume execution
// - powerdown flag set at power-up, cleared when sleep takes effect
// - only clockless peripherals may wake the device from sleep
// - sleep prefetches the instruction at the next address
// - source wakes only if individually enabled, regardless of global enable
// - after wake run prefetched instruction, then vector to 0004h if enabled
// - enabled interrupt pending before sleep makes sleep a no-op
// - interrupt during or after sleep: finish sleep fully, then wake
// - crystal modes wait 1024 oscillator periods on wake; rc mode does not
// - interrupt entry pushes only the return address
// - global interrupt enable at bit 7, cleared on reset
`include "wsc_defines.vh"

module wsc_top (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire [15:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output wire s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output wire s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [15:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output wire s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   input wire wdt_osc_in,
   input wire master_clear_pin_n_in,
   input wire clear_watchdog_instr_in,
   input wire sleep_instr_in,
   input wire irq_return_instr_in,
   input wire [12:0] pc_in,
   input wire int_flag_in,
   input wire rb_flag_in,
   input wire periph_irq_in,
   input wire periph_clockless_in,
   input wire tmr0_src_tick_in,
   output reg tmr0_inc_out,
   input wire [7:0] port_drive_in,
   input wire [7:0] port_oe_in,
   output reg [7:0] port_drive_out,
   output reg [7:0] port_oe_out,
   output reg device_reset_out,
   output wire sleeping_out,
   output reg osc_driver_en_out,
   output reg resume_out,
   output reg [12:0] prefetch_addr_out,
   output reg irq_vector_req_out,
   output wire [12:0] irq_vector_addr_out,
   output reg stack_push_out,
   output reg [12:0] stack_data_out,
   output reg sleep_nop_out
);

   localparam [4:0] ST_RUN = 5'b00001;
   localparam [4:0] ST_SLEEP = 5'b00010;
   localparam [4:0] ST_OST = 5'b00100;
   localparam [4:0] ST_RESUME = 5'b01000;
   localparam [4:0] ST_VECTOR = 5'b10000;
   localparam [31:0] OST_CYC32 = `WSC_OST_CYCLES;
   localparam [10:0] OST_LOAD = OST_CYC32[10:0] - 11'h001;

   reg [7:0] cfg_q;
   reg [7:0] opt_q;
   reg [7:0] irqctl_q;
   reg to_q;
   reg pd_q;
   reg [4:0] state_q;
   reg [10:0] ost_cnt_q;
   reg [7:0] wdt_cnt_q;
   reg [7:0] presc_q;
   reg vec_pend_q;
   reg [2:0] osc_sync_q;
   reg osc_lvl_q;
   reg [2:0] master_clear_pin_sync_q;
   reg master_clear_pin_lvl_q;

   // rc oscillator and master clear come from outside the core clock
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_sync_q <= 3'b000;
         osc_lvl_q <= 1'b0;
         master_clear_pin_sync_q <= 3'b111;
         master_clear_pin_lvl_q <= 1'b1;
      end else begin
         osc_sync_q <= {osc_sync_q[1:0], wdt_osc_in};
         master_clear_pin_sync_q <= {master_clear_pin_sync_q[1:0], master_clear_pin_n_in};
         if (osc_sync_q[2] == osc_sync_q[1]) begin
            osc_lvl_q <= osc_sync_q[2];
         end
         if (master_clear_pin_sync_q[2] == master_clear_pin_sync_q[1]) begin
            master_clear_pin_lvl_q <= master_clear_pin_sync_q[2];
         end
      end
   end

   wire rc_tick = (osc_sync_q[2] == osc_sync_q[1]) & osc_sync_q[2] & ~osc_lvl_q;
   wire master_clear_pin_active = ~master_clear_pin_lvl_q;
   wire wdt_en = cfg_q[`WSC_CFG_WATCHDOG_ENABLE_FUSE];
   wire prescaler_assign = opt_q[`WSC_OPT_PSA];
   wire [2:0] ps_sel = opt_q[`WSC_OPT_PS_HI:`WSC_OPT_PS_LO];
   wire in_run = state_q[0];
   wire in_sleep = state_q[1];
   wire asleep = state_q[1] | state_q[2];
   wire global_irq_enable = irqctl_q[`WSC_IC_GIE];

   // watchdog ratio is 2^ps, timer ratio 2^(ps+1)
   wire [7:0] ps_mask = prescaler_assign ? ((8'h01 << ps_sel) - 8'h01) : ((8'h02 << ps_sel) - 8'h01);
   wire wdt_ovf = wdt_en & rc_tick & (&wdt_cnt_q);
   wire presc_src = prescaler_assign ? wdt_ovf : tmr0_src_tick_in;
   wire presc_done = presc_src & ((presc_q & ps_mask) == ps_mask);
   wire wdt_timeout = wdt_en & (prescaler_assign ? presc_done : wdt_ovf);

   // only clockless peripherals can request wake while asleep
   wire periph_ok = periph_irq_in & (~asleep | periph_clockless_in);
   wire irq_pend = (irqctl_q[`WSC_IC_INTE] & int_flag_in) |
                   (irqctl_q[`WSC_IC_RBIE] & rb_flag_in) |
                   (irqctl_q[`WSC_IC_PEIE] & periph_ok);

   wire dev_rst = master_clear_pin_active | (wdt_timeout & ~asleep);
   wire sleep_take = in_run & sleep_instr_in & ~irq_pend & ~dev_rst;
   wire sleep_nop = in_run & sleep_instr_in & irq_pend & ~dev_rst;
   wire clr_take = in_run & clear_watchdog_instr_in & ~dev_rst;
   wire wdt_clear = clr_take | sleep_take;
   wire rc_mode = cfg_q[`WSC_CFG_FOSC_HI:`WSC_CFG_FOSC_LO] == `WSC_FOSC_RC;

   assign sleeping_out = asleep;
   assign irq_vector_addr_out = `WSC_IRQ_VECTOR;

   // watchdog counter and shared prescaler
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wdt_cnt_q <= 8'h00;
         presc_q <= 8'h00;
         tmr0_inc_out <= 1'b0;
      end else begin
         tmr0_inc_out <= prescaler_assign ? tmr0_src_tick_in : presc_done;
         if (wdt_clear || dev_rst || !wdt_en) begin
            wdt_cnt_q <= 8'h00;
         end else if (rc_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 8'h01;
         end
         if (wdt_clear && prescaler_assign) begin
            presc_q <= 8'h00;
         end else if (dev_rst) begin
            presc_q <= 8'h00;
         end else if (presc_src) begin
            presc_q <= presc_done ? 8'h00 : presc_q + 8'h01;
         end
      end
   end

   // timeout and powerdown flags
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         to_q <= 1'b1;
         pd_q <= 1'b1;
      end else begin
         if (wdt_timeout) begin
            to_q <= 1'b0;
         end else if (master_clear_pin_active && asleep) begin
            to_q <= 1'b1;
         end else if (wdt_clear) begin
            to_q <= 1'b1;
         end
         if (sleep_take) begin
            pd_q <= 1'b0;
         end else if (clr_take || (wdt_timeout && !asleep)) begin
            pd_q <= 1'b1;
         end
      end
   end

   // sleep and wake sequencer
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_RUN;
         ost_cnt_q <= 11'h000;
         vec_pend_q <= 1'b0;
         device_reset_out <= 1'b0;
         osc_driver_en_out <= 1'b1;
         resume_out <= 1'b0;
         prefetch_addr_out <= 13'h0000;
         irq_vector_req_out <= 1'b0;
         stack_push_out <= 1'b0;
         stack_data_out <= 13'h0000;
         sleep_nop_out <= 1'b0;
         port_drive_out <= 8'h00;
         port_oe_out <= 8'h00;
      end else begin
         device_reset_out <= dev_rst;
         resume_out <= 1'b0;
         irq_vector_req_out <= 1'b0;
         stack_push_out <= 1'b0;
         sleep_nop_out <= sleep_nop;
         if (!asleep) begin
            port_drive_out <= port_drive_in;
            port_oe_out <= port_oe_in;
         end
         if (dev_rst) begin
            state_q <= ST_RUN;
            osc_driver_en_out <= 1'b1;
            vec_pend_q <= 1'b0;
         end else begin
            case (state_q)
               ST_RUN: begin
                  if (sleep_take) begin
                     prefetch_addr_out <= pc_in + `WSC_PC_ONE;
                     osc_driver_en_out <= 1'b0;
                     state_q <= ST_SLEEP;
                  end else if (global_irq_enable && irq_pend && !sleep_instr_in) begin
                     stack_data_out <= pc_in;
                     state_q <= ST_VECTOR;
                  end
               end
               ST_SLEEP: begin
                  // a wake already pending at entry is seen here, after sleep fully took effect
                  if (wdt_timeout || irq_pend) begin
                     vec_pend_q <= irq_pend & global_irq_enable;
                     osc_driver_en_out <= 1'b1;
                     ost_cnt_q <= OST_LOAD;
                     state_q <= rc_mode ? ST_RESUME : ST_OST;
                  end
               end
               ST_OST: begin
                  if (ost_cnt_q == 11'h000) begin
                     state_q <= ST_RESUME;
                  end else begin
                     ost_cnt_q <= ost_cnt_q - 11'h001;
                  end
               end
               ST_RESUME: begin
                  resume_out <= 1'b1;
                  stack_data_out <= prefetch_addr_out + `WSC_PC_ONE;
                  state_q <= vec_pend_q ? ST_VECTOR : ST_RUN;
                  vec_pend_q <= 1'b0;
               end
               ST_VECTOR: begin
                  irq_vector_req_out <= 1'b1;
                  stack_push_out <= 1'b1;
                  state_q <= ST_RUN;
               end
               default: begin
                  state_q <= ST_RUN;
               end
            endcase
         end
      end
   end

   // axi4-lite slave: address and data may arrive in either order
   reg aw_full_q;
   reg w_full_q;
   reg [15:0] aw_addr_q;
   reg [7:0] w_data_q;
   reg w_strb_q;

   assign s_axi_awready_out = ~aw_full_q;
   assign s_axi_wready_out = ~w_full_q;
   assign s_axi_arready_out = ~s_axi_rvalid_out;

   wire do_write = aw_full_q & w_full_q & ~s_axi_bvalid_out;
   wire wr_cfg = do_write & w_strb_q & (aw_addr_q == `WSC_CFG_ADDR);
   wire wr_opt = do_write & w_strb_q & (aw_addr_q == `WSC_OPT_ADDR);
   wire wr_ic = do_write & w_strb_q & (aw_addr_q == `WSC_IRQCTL_ADDR);
   wire wr_hit = (aw_addr_q == `WSC_CFG_ADDR) | (aw_addr_q == `WSC_OPT_ADDR) |
                 (aw_addr_q == `WSC_IRQCTL_ADDR) | (aw_addr_q == `WSC_STATUS_ADDR);

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 16'h0000;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `WSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_in && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata_in[7:0];
            w_strb_q <= s_axi_wstrb_in[0];
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit ? `WSC_RESP_OKAY : `WSC_RESP_SLVERR;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // software steers config, option and interrupt enables
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q <= `WSC_CFG_RESET;
         opt_q <= `WSC_OPT_RESET;
         irqctl_q <= `WSC_IRQCTL_RESET;
      end else begin
         if (wr_cfg) begin
            cfg_q <= w_data_q;
         end
         if (wr_opt) begin
            opt_q <= w_data_q;
         end
         if (dev_rst) begin
            irqctl_q[`WSC_IC_GIE] <= 1'b0;
         end else if (state_q == ST_VECTOR) begin
            irqctl_q[`WSC_IC_GIE] <= 1'b0;
         end else if (irq_return_instr_in) begin
            irqctl_q[`WSC_IC_GIE] <= 1'b1;
         end else if (wr_ic) begin
            irqctl_q[`WSC_IC_GIE] <= w_data_q[`WSC_IC_GIE];
         end
         if (wr_ic) begin
            irqctl_q[`WSC_IC_PEIE] <= w_data_q[`WSC_IC_PEIE];
            irqctl_q[`WSC_IC_INTE] <= w_data_q[`WSC_IC_INTE];
            irqctl_q[`WSC_IC_RBIE] <= w_data_q[`WSC_IC_RBIE];
         end
      end
   end

   reg [7:0] rd_byte;
   reg rd_hit;
   always @* begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (s_axi_araddr_in)
         `WSC_CFG_ADDR: rd_byte = cfg_q;
         `WSC_OPT_ADDR: rd_byte = opt_q;
         `WSC_IRQCTL_ADDR: rd_byte = irqctl_q & 8'hD8;
         `WSC_STATUS_ADDR: rd_byte = {3'b000, to_q, pd_q, 3'b000};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `WSC_RESP_OKAY;
      end else begin
         if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= {24'h00_0000, rd_byte};
            s_axi_rresp_out <= rd_hit ? `WSC_RESP_OKAY : `WSC_RESP_SLVERR;
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

endmodule

// ===== logic/wsc_defines.vh
`ifndef WSC_DEFINES_VH
`define WSC_DEFINES_VH

// register indices as printed; byte address is four times the index
`define WSC_CFG_IDX 14'h2007
`define WSC_OPT_IDX 14'h0081
`define WSC_CFG_ADDR {`WSC_CFG_IDX, 2'b00}
`define WSC_OPT_ADDR {`WSC_OPT_IDX, 2'b00}
`define WSC_STATUS_ADDR 16'h0000
`define WSC_IRQCTL_ADDR 16'h0004

`define WSC_CFG_RESET 8'hFF
`define WSC_OPT_RESET 8'hFF
`define WSC_IRQCTL_RESET 8'h00

// config word fields
`define WSC_CFG_WATCHDOG_ENABLE_FUSE 2
`define WSC_CFG_FOSC_HI 1
`define WSC_CFG_FOSC_LO 0
`define WSC_FOSC_RC 2'b11

// option register fields
`define WSC_OPT_PSA 3
`define WSC_OPT_PS_HI 2
`define WSC_OPT_PS_LO 0

// status fields
`define WSC_ST_TO 4
`define WSC_ST_PD 3

// interrupt control fields
`define WSC_IC_GIE 7
`define WSC_IC_PEIE 6
`define WSC_IC_INTE 4
`define WSC_IC_RBIE 3

`define WSC_IRQ_VECTOR 13'h0004
`define WSC_PC_ONE 13'h0001
`define WSC_PC_TWO 13'h0002

// oscillator start-up delay: 1024 oscillator periods
`define WSC_OST_OSC_PERIOD 1024
`define WSC_OSC_PERIOD_NS 8
`define WSC_CLK_NS 8
`define WSC_OST_CYCLES ((`WSC_OST_OSC_PERIOD * `WSC_OSC_PERIOD_NS + `WSC_CLK_NS - 1) / `WSC_CLK_NS)

`define WSC_RESP_OKAY 2'b00
`define WSC_RESP_SLVERR 2'b10

`endif

// ===== test/wsc_wdt_monitor.sv
`timescale 1ns/1ns
module wsc_wdt_monitor (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire master_clear_pin_n_in,
   input wire sleep_instr_in,
   input wire [12:0] pc_in,
   input wire [7:0] port_drive_in,
   input wire [7:0] port_drive_out,
   input wire [7:0] port_oe_out,
   input wire device_reset_out,
   input wire sleeping_out,
   input wire osc_driver_en_out,
   input wire resume_out,
   input wire [12:0] prefetch_addr_out,
   input wire irq_vector_req_out,
   input wire [12:0] irq_vector_addr_out,
   input wire stack_push_out,
   input wire sleep_nop_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   osc_off_a: assert property (!osc_driver_en_out |-> sleeping_out)
      else $error("oscillator off while awake");
   sleep_entry_a: assert property (sleep_instr_in && !sleeping_out && !device_reset_out |=> sleeping_out || sleep_nop_out)
      else $error("sleep neither entered nor refused");
   nop_awake_a: assert property (sleep_nop_out |-> !sleeping_out)
      else $error("refused sleep still entered sleep");
   prefetch_a: assert property ($rose(sleeping_out) |-> prefetch_addr_out == $past(pc_in) + 13'h0001)
      else $error("prefetch address not next address");
   port_hold_a: assert property (sleeping_out && $past(sleeping_out) |-> $stable(port_drive_out) && $stable(port_oe_out))
      else $error("port state moved during sleep");
   // reset release excluded: the input seen during reset is not what was captured
   port_follow_a: assert property (!sleeping_out && !$past(sleeping_out) && $past(rst_n_in) |-> port_drive_out == $past(port_drive_in))
      else $error("port state not following core while awake");
   vector_push_a: assert property (irq_vector_req_out |-> stack_push_out && irq_vector_addr_out == 13'h0004)
      else $error("vector without return push or wrong vector");
   master_clear_pin_reset_a: assert property (!master_clear_pin_n_in [*6] |-> device_reset_out)
      else $error("master clear gave no reset");
   wdt_pulse_a: assert property (device_reset_out && master_clear_pin_n_in && $past(master_clear_pin_n_in, 6) |=> !device_reset_out)
      else $error("watchdog reset longer than one cycle");
   resume_after_a: assert property (resume_out |-> $past(sleeping_out) || $past(sleeping_out, 2) || $past(sleeping_out, 3))
      else $error("resume without sleep");

   cover property (resume_out);
   cover property (sleep_nop_out);
   cover property (irq_vector_req_out);
   cover property (device_reset_out && master_clear_pin_n_in);
endmodule

// ===== test/wsc_core_model.sv
`timescale 1ns/1ns
module wsc_core_model (
   input wire core_clk_in,
   output reg clear_watchdog_instr_out,
   output reg sleep_out,
   output reg [12:0] pc_out
);
   initial begin
      clear_watchdog_instr_out = 0;
      sleep_out = 0;
      pc_out = 0;
   end
   // one executed instruction: sleep at address p, else clear-watchdog
   task op(input reg s, input [12:0] p);
      begin
         // idle edge first: back-to-back calls never re-drive a strobe in the step that dropped it
         @(posedge core_clk_in);
         sleep_out <= s;
         clear_watchdog_instr_out <= !s;
         pc_out <= p;
         @(posedge core_clk_in);
         sleep_out <= 0;
         clear_watchdog_instr_out <= 0;
         // address bus is only meaningful with the sleep strobe or at interrupt entry from run
         pc_out <= ~p;
      end
   endtask
endmodule

// ===== test/wsc_top_bench.sv
`timescale 1ns/1ns
`include "wsc_defines.vh"
module wsc_top_bench;
   logic core_clk_in = 0, rst_n_in = 0;
   logic [15:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
   logic [31:0] s_axi_wdata_in = 0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 1, s_axi_arvalid_in = 0, s_axi_rready_in = 1;
   logic wdt_osc_in = 0, master_clear_pin_n_in = 1, irq_return_instr_in = 0, tmr0_src_tick_in = 0;
   logic int_flag_in = 0, rb_flag_in = 0, periph_irq_in = 0, periph_clockless_in = 0;
   logic [7:0] port_drive_in = 0, port_oe_in = 0;
   wire clear_watchdog_instr_in, sleep_instr_in;
   wire [12:0] pc_in, prefetch_addr_out, irq_vector_addr_out, stack_data_out;
   wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, tmr0_inc_out;
   wire device_reset_out, sleeping_out, osc_driver_en_out, resume_out, irq_vector_req_out, stack_push_out, sleep_nop_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out;
   wire [7:0] port_drive_out, port_oe_out;
   integer fail_count = 0, total_checks = 0, cyc, incs = 0, n0, i;
   logic [7:0] en [0:2] = '{8'h10, 8'h08, 8'h40};

   wsc_top u_dut (.*);
   wsc_core_model u_core (.core_clk_in(core_clk_in), .clear_watchdog_instr_out(clear_watchdog_instr_in), .sleep_out(sleep_instr_in),
      .pc_out(pc_in));

   always #4 core_clk_in = ~core_clk_in;
   // odd half period keeps the rc clock drifting against the core clock
   always #41 wdt_osc_in = ~wdt_osc_in;
   always @(posedge core_clk_in) if (tmr0_inc_out) incs <= incs + 1;

   task results;
      begin
         $display("checks %0d errors %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         total_checks++;
         if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
         end
      end
   endtask
   task tmo;
      begin
         chk(0, 1);
         results;
      end
   endtask
   task wr(input [15:0] a, input [31:0] d, input [1:0] er);
      integer n;
      begin
         s_axi_awaddr_in <= a;
         s_axi_wdata_in <= d;
         s_axi_awvalid_in <= 1;
         s_axi_wvalid_in <= 1;
         for (n = 0; n < 50; n++) begin
            @(posedge core_clk_in);
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 0;
            if (s_axi_bvalid_out) break;
         end
         if (n == 50) tmo;
         chk(s_axi_bresp_out, er);
      end
   endtask
   task rd(input [15:0] a, input [31:0] e, input [1:0] er);
      integer n;
      begin
         s_axi_araddr_in <= a;
         s_axi_arvalid_in <= 1;
         for (n = 0; n < 50; n++) begin
            @(posedge core_clk_in);
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 0;
            if (s_axi_rvalid_out) break;
         end
         if (n == 50) tmo;
         chk(s_axi_rdata_out, e);
         chk(s_axi_rresp_out, er);
      end
   endtask
   // s: 0 resume, 1 device reset, 2 vector, 3 refused sleep; ex says whether it must come
   task wt(input integer s, input integer lim, input reg ex);
      reg got;
      begin
         got = 0;
         for (cyc = 0; cyc < lim && !got; cyc++) begin
            @(posedge core_clk_in);
            got = (s == 0 ? resume_out : s == 1 ? device_reset_out : s == 2 ? irq_vector_req_out : sleep_nop_out) === 1'b1;
         end
         if (ex && !got) tmo;
         else chk(got, ex);
      end
   endtask

   initial begin
      repeat (6) @(posedge core_clk_in);
      rst_n_in <= 1;
      @(posedge core_clk_in);
      rd(`WSC_STATUS_ADDR, 32'h0000_0018, `WSC_RESP_OKAY);
      rd(`WSC_IRQCTL_ADDR, 32'h0000_0000, `WSC_RESP_OKAY);
      rd(`WSC_CFG_ADDR, 32'h0000_00ff, `WSC_RESP_OKAY);
      rd(`WSC_OPT_ADDR, 32'h0000_00ff, `WSC_RESP_OKAY);
      rd(16'h0100, 32'h0000_0000, `WSC_RESP_SLVERR);
      wr(16'h0100, 32'h0000_0000, `WSC_RESP_SLVERR);
      wr(`WSC_STATUS_ADDR, 32'h0000_0000, `WSC_RESP_OKAY);
      rd(`WSC_STATUS_ADDR, 32'h0000_0018, `WSC_RESP_OKAY);
      for (i = 0; i < 2; i++) begin
         wr(`WSC_OPT_ADDR, i * 8, `WSC_RESP_OKAY);
         n0 = incs;
         repeat (8) begin
            tmr0_src_tick_in <= 1;
            @(posedge core_clk_in);
            tmr0_src_tick_in <= 0;
            @(posedge core_clk_in);
         end
         repeat (3) @(posedge core_clk_in);
         chk(incs - n0, i ? 8 : 4);
      end
      repeat (30) begin
         u_core.op(0, 13'h0000);
         wt(1, 100, 0);
      end
      rd(`WSC_OPT_ADDR, 32'h0000_0008, `WSC_RESP_OKAY);
      wt(1, 3000, 1);
      rd(`WSC_STATUS_ADDR, 32'h0000_0008, `WSC_RESP_OKAY);
      periph_clockless_in <= 1;
      for (i = 0; i < 3; i++) begin
         wr(`WSC_IRQCTL_ADDR, en[i], `WSC_RESP_OKAY);
         u_core.op(0, 13'h0000);
         port_drive_in <= 8'ha5;
         port_oe_in <= 8'h0f;
         u_core.op(1, 13'h0100 * (i + 1));
         rd(`WSC_STATUS_ADDR, 32'h0000_0010, `WSC_RESP_OKAY);
         chk(osc_driver_en_out, 0);
         port_drive_in <= 8'h3c;
         port_oe_in <= 8'hf0;
         {periph_irq_in, rb_flag_in, int_flag_in} <= 3'b001 << ((i + 1) % 3);
         wt(0, 30, 0);
         chk(port_drive_out, 8'ha5);
         chk(port_oe_out, 8'h0f);
         {periph_irq_in, rb_flag_in, int_flag_in} <= 3'b001 << i;
         wt(0, 20, 1);
         chk(prefetch_addr_out, 13'h0100 * (i + 1) + 1);
         wt(2, 5, 0);
         u_core.op(0, 13'h0000);
         u_core.op(1, 13'h0010);
         wt(3, 4, 1);
         rd(`WSC_STATUS_ADDR, 32'h0000_0018, `WSC_RESP_OKAY);
         {periph_irq_in, rb_flag_in, int_flag_in} <= 3'b000;
      end
      periph_clockless_in <= 0;
      u_core.op(0, 13'h0000);
      u_core.op(1, 13'h0400);
      periph_irq_in <= 1;
      wt(0, 40, 0);
      periph_clockless_in <= 1;
      wt(0, 20, 1);
      periph_irq_in <= 0;
      wr(`WSC_IRQCTL_ADDR, 32'h0000_0090, `WSC_RESP_OKAY);
      u_core.op(1, 13'h0300);
      int_flag_in <= 1;
      wt(0, 20, 1);
      wt(2, 3, 1);
      chk(stack_push_out, 1);
      chk(stack_data_out, 13'h0302);
      int_flag_in <= 0;
      rd(`WSC_IRQCTL_ADDR, 32'h0000_0010, `WSC_RESP_OKAY);
      rd(`WSC_STATUS_ADDR, 32'h0000_0010, `WSC_RESP_OKAY);
      wr(`WSC_IRQCTL_ADDR, 32'h0000_0000, `WSC_RESP_OKAY);
      u_core.op(0, 13'h0000);
      u_core.op(1, 13'h0500);
      wt(0, 3000, 1);
      rd(`WSC_STATUS_ADDR, 32'h0000_0000, `WSC_RESP_OKAY);
      wr(`WSC_CFG_ADDR, 32'h0000_00f8, `WSC_RESP_OKAY);
      wr(`WSC_IRQCTL_ADDR, 32'h0000_0010, `WSC_RESP_OKAY);
      u_core.op(1, 13'h0600);
      int_flag_in <= 1;
      wt(0, 2000, 1);
      chk(cyc >= 1024, 1);
      int_flag_in <= 0;
      wt(1, 3000, 0);
      u_core.op(1, 13'h0700);
      master_clear_pin_n_in <= 0;
      wt(1, 10, 1);
      chk(sleeping_out, 0);
      master_clear_pin_n_in <= 1;
      repeat (8) @(posedge core_clk_in);
      results;
   end
endmodule

bind wsc_top wsc_wdt_monitor u_mon (.*);
